// [rtl/compare_alu.sv]
`timescale 1ns/100ps
`include "cpu_consts.svh"

module compare_alu
(
  // operands
  input  cpu_pkg::word_type  minuend,
  input  cpu_pkg::word_type  subtrahend,
  // result flags
  output cpu_pkg::flags_type flags
);
  import cpu_pkg::*;

  logic [24:0] diff;
  word_type    res;

  always_comb
  begin
    diff  = {1'b0, minuend} - {1'b0, subtrahend};
    res   = diff[23:0];
    flags = '0;
    // carry is the borrow of the unsigned subtraction
    flags[`FLAG_C] = diff[24];
    flags[`FLAG_O] = (minuend[23] ^ subtrahend[23]) & (minuend[23] ^ res[23]);
    flags[`FLAG_S] = res[23];
    flags[`FLAG_Z] = (res == 24'h000000);
  end

endmodule

// [rtl/cpu_clock_flag_compare_ops.sv]
// Contract
// - slow clock opcode with operand 1 runs the processor from 10 kHz.
// - its one-bit operand turns the slow clock on (1) or back off (0).
// - slow clock opcode is two bytes and takes three processor cycles.
// - clear opcode is one byte, one cycle, zeroes carry and overflow only.
// - watchdog restart is two bytes and clears the watchdog count.
// - compare sets C, O, S, Z from p2 minus p1 and writes no register.
// - compare p1 is an accumulator, p2 an accumulator or 24-bit constant.
// - accumulator compare is 1 byte 1 cycle, immediate is 4 bytes 4 cycles.
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "cpu_consts.svh"

module cpu_clock_flag_compare_ops
#(
  parameter int SLOW_DIV = `SLOW_DIV_CYCLES,
  parameter int WDT_W    = `WDT_WIDTH
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // instruction byte stream
  input  wire logic [7:0]  instr_byte,
  input  wire logic        instr_valid,
  output logic             instr_ready,
  // processor clock state
  output logic             slow_clk_sel,
  output logic             cpu_tick
);
  import cpu_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  exec_state_type state_reg, state_next;
  op_kind_type    kind_reg, kind_next;
  logic [1:0]     left_reg, left_next;
  logic [1:0]     p1_reg, p1_next;
  logic [15:0]    imm_reg, imm_next;
  logic           opnd_reg, opnd_next;
  logic           slow_reg, slow_next;
  flags_type      flags_reg, flags_next;
  logic           run_reg, run_next;
  logic           illegal_reg, illegal_next;
  logic           wdt_to_reg, wdt_to_next;
  logic [1:0]     cyc_reg, cyc_next;
  logic [11:0]    div_reg, div_next;
  logic           ack_reg, ack_next;
  logic [31:0]    rdata_reg, rdata_next;
  word_type       acc_reg [4];
  word_type       acc_next [4];

  logic             take, bus_wr, wdt_clear, wdt_timeout;
  logic             clk_apply, cmp_acc_exec, cmp_imm_exec, clr_exec;
  logic [4:0]       wofs;
  word_type         cmp_p1, cmp_p2;
  flags_type        alu_flags;
  logic [WDT_W-1:0] wdt_count;

  // ****************************************************************
  // processor cycle enable
  // ****************************************************************
  // fast source is above clk, so it runs at one cycle per clk
  assign cpu_tick     = slow_reg ? (div_reg == 12'(SLOW_DIV - 1)) : 1'b1;
  assign slow_clk_sel = slow_reg;

  always_comb
  begin
    div_next = div_reg + 12'h001;
    if (!slow_reg || cpu_tick)
      div_next = 12'h000;
  end

  // ****************************************************************
  // avalon slave
  // ****************************************************************
  assign wofs            = {avs_address[4:2], 2'b00};
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata    = rdata_reg;
  assign bus_wr          = avs_write & ack_reg;

  always_comb
  begin
    ack_next   = (avs_read | avs_write) & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read && !ack_reg)
    begin
      rdata_next = 32'h00000000;
      if (wofs < `ADDR_FLAGS)
        rdata_next = {8'h00, acc_reg[avs_address[3:2]]};
      else if (wofs == `ADDR_FLAGS)
        rdata_next = {28'h0000000, flags_reg};
      else if (wofs == `ADDR_CTRL)
        rdata_next = {31'h00000000, run_reg};
      else if (wofs == `ADDR_STATUS)
        rdata_next = {28'h0000000, wdt_to_reg, illegal_reg,
                      (state_reg != ST_FETCH), slow_reg};
      else if (wofs == `ADDR_WDT_COUNT)
        rdata_next = {{(32 - WDT_W){1'b0}}, wdt_count};
    end
  end

  // ****************************************************************
  // accumulators
  // ****************************************************************
  // only the bus writes them; no opcode here has a register result
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_acc
      always_comb
      begin
        acc_next[gi] = acc_reg[gi];
        if (bus_wr && wofs == 5'(`ADDR_ACC_X + 4 * gi))
          acc_next[gi] = avs_writedata[23:0];
      end

      always_ff @(posedge clk)
      begin
        if (rst)
          acc_reg[gi] <= `ACC_RST;
        else
          acc_reg[gi] <= acc_next[gi];
      end
    end
  endgenerate

  // ****************************************************************
  // compare datapath
  // ****************************************************************
  always_comb
  begin
    cmp_p1 = acc_reg[instr_byte[3:2]];
    cmp_p2 = acc_reg[instr_byte[1:0]];
    if (state_reg == ST_OPERAND)
    begin
      cmp_p1 = acc_reg[p1_reg];
      cmp_p2 = {imm_reg, instr_byte};
    end
  end

  compare_alu u_alu
  (
    .minuend    (cmp_p2),
    .subtrahend (cmp_p1),
    .flags      (alu_flags)
  );

  watchdog_counter #(.WIDTH(WDT_W)) u_wdt
  (
    .clk     (clk),
    .rst     (rst),
    .tick    (cpu_tick),
    .clear   (wdt_clear),
    .count   (wdt_count),
    .timeout (wdt_timeout)
  );

  // ****************************************************************
  // decode and execute
  // ****************************************************************
  assign instr_ready = run_reg & cpu_tick & (state_reg != ST_SETTLE);
  assign take        = instr_ready & instr_valid;

  always_comb
  begin
    state_next   = state_reg;
    kind_next    = kind_reg;
    left_next    = left_reg;
    p1_next      = p1_reg;
    imm_next     = imm_reg;
    opnd_next    = opnd_reg;
    slow_next    = slow_reg;
    flags_next   = flags_reg;
    cyc_next     = cyc_reg;
    illegal_next = illegal_reg;
    wdt_clear    = 1'b0;
    clk_apply    = 1'b0;
    cmp_acc_exec = 1'b0;
    cmp_imm_exec = 1'b0;
    clr_exec     = 1'b0;
    if (bus_wr && wofs == `ADDR_FLAGS)
      flags_next = avs_writedata[3:0];
    if (bus_wr && wofs == `ADDR_STATUS && avs_writedata[`STAT_ILLEGAL])
      illegal_next = 1'b0;
    unique case (state_reg)
      ST_FETCH:
        if (take)
        begin
          cyc_next = 2'd1;
          if (instr_byte == `OP_SLOW_CLK)
          begin
            kind_next  = K_CLK;
            left_next  = `OPERAND_BYTES_1;
            state_next = ST_OPERAND;
          end
          else if (instr_byte == `OP_CLR_CO)
          begin
            clr_exec = 1'b1;
            flags_next[`FLAG_C] = 1'b0;
            flags_next[`FLAG_O] = 1'b0;
          end
          else if (instr_byte == `OP_WDT_CLR)
          begin
            kind_next  = K_WDT;
            left_next  = `OPERAND_BYTES_1;
            state_next = ST_OPERAND;
          end
          else if (instr_byte[7:4] == `OP_CMP_ACC_HI)
          begin
            cmp_acc_exec = 1'b1;
            flags_next   = alu_flags;
          end
          else if (instr_byte[7:2] == `OP_CMP_IMM_HI)
          begin
            kind_next  = K_CMP;
            p1_next    = instr_byte[1:0];
            left_next  = `CMP_IMM_BYTES;
            state_next = ST_OPERAND;
          end
          else
            illegal_next = 1'b1;
        end
      ST_OPERAND:
        if (take)
        begin
          cyc_next  = cyc_reg + 2'd1;
          left_next = left_reg - 2'd1;
          imm_next  = {imm_reg[7:0], instr_byte};
          if (left_reg == 2'd1)
          begin
            state_next = ST_FETCH;
            unique case (kind_reg)
              K_CLK:
              begin
                opnd_next  = instr_byte[0];
                state_next = ST_SETTLE;
              end
              K_WDT:
                wdt_clear = 1'b1;
              K_CMP:
              begin
                cmp_imm_exec = 1'b1;
                flags_next   = alu_flags;
              end
              default:
                illegal_next = 1'b1;
            endcase
          end
        end
      ST_SETTLE:
        if (cpu_tick)
        begin
          // source swaps on the third cycle, not mid-operand
          clk_apply  = 1'b1;
          slow_next  = opnd_reg;
          state_next = ST_FETCH;
        end
      default:
        state_next = ST_FETCH;
    endcase
  end

  always_comb
  begin
    run_next    = run_reg;
    wdt_to_next = wdt_to_reg;
    if (bus_wr && wofs == `ADDR_CTRL)
      run_next = avs_writedata[`CTRL_RUN];
    if (bus_wr && wofs == `ADDR_STATUS && avs_writedata[`STAT_WDT_TO])
      wdt_to_next = 1'b0;
    // a timeout in the clearing cycle still sticks
    if (wdt_timeout)
      wdt_to_next = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg   <= ST_FETCH;
      kind_reg    <= K_CLK;
      left_reg    <= 2'd0;
      p1_reg      <= 2'd0;
      imm_reg     <= 16'h0000;
      opnd_reg    <= 1'b0;
      slow_reg    <= 1'b0;
      flags_reg   <= `FLAGS_RST;
      run_reg     <= `CTRL_RUN_RST;
      illegal_reg <= 1'b0;
      wdt_to_reg  <= 1'b0;
      cyc_reg     <= 2'd0;
      div_reg     <= 12'h000;
      ack_reg     <= 1'b0;
      rdata_reg   <= 32'h00000000;
    end
    else
    begin
      state_reg   <= state_next;
      kind_reg    <= kind_next;
      left_reg    <= left_next;
      p1_reg      <= p1_next;
      imm_reg     <= imm_next;
      opnd_reg    <= opnd_next;
      slow_reg    <= slow_next;
      flags_reg   <= flags_next;
      run_reg     <= run_next;
      illegal_reg <= illegal_next;
      wdt_to_reg  <= wdt_to_next;
      cyc_reg     <= cyc_next;
      div_reg     <= div_next;
      ack_reg     <= ack_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_slow_sel_on: assert property (
    clk_apply && opnd_reg |=> slow_clk_sel ##1 slow_clk_sel)
    else $error("slow clock not selected");
  a_slow_sel_off: assert property (
    clk_apply && !opnd_reg |=> !slow_clk_sel && cpu_tick)
    else $error("slow clock not released");
  a_clk_three_cyc: assert property (
    clk_apply |-> cyc_reg == 2'd2 && kind_reg == K_CLK)
    else $error("clock switch not on third cycle");
  a_clr_co_only: assert property (
    clr_exec && !bus_wr |=> !flags_reg[`FLAG_C] && !flags_reg[`FLAG_O]
      && flags_reg[1:0] == $past(flags_reg[1:0]) && state_reg == ST_FETCH)
    else $error("clear flags opcode wrong");
  a_wdt_cleared: assert property (
    wdt_clear |=> wdt_count == '0)
    else $error("watchdog not cleared");
  a_wdt_two_cyc: assert property (
    wdt_clear && !bus_wr |-> cyc_reg == 2'd1 ##1 $stable(flags_reg))
    else $error("watchdog restart timing or flags wrong");
  a_cmp_zero_flag: assert property (
    (cmp_acc_exec || cmp_imm_exec) |=>
      flags_reg[`FLAG_Z] == ($past(cmp_p2) == $past(cmp_p1))
      && flags_reg[`FLAG_C] == ($past(cmp_p2) < $past(cmp_p1)))
    else $error("compare flags wrong");
  a_cmp_no_write: assert property (
    (cmp_acc_exec || cmp_imm_exec) && !bus_wr |=>
      acc_reg[0] == $past(acc_reg[0]) && acc_reg[3] == $past(acc_reg[3]))
    else $error("compare wrote an accumulator");
  a_cmp_imm_four: assert property (
    cmp_imm_exec |-> cyc_reg == 2'd3 && cmp_p2[7:0] == instr_byte)
    else $error("immediate compare not on fourth cycle");
  a_cmp_acc_one: assert property (
    cmp_acc_exec |-> state_reg == ST_FETCH ##1 state_reg == ST_FETCH)
    else $error("accumulator compare not single cycle");

  c_slow_on: cover property (clk_apply && opnd_reg);
  c_cmp_imm: cover property (cmp_imm_exec);
  c_wdt_clr: cover property (wdt_clear);
  c_clr_co: cover property (clr_exec);

endmodule

// [rtl/cpu_consts.svh]
`ifndef CPU_CONSTS_SVH
`define CPU_CONSTS_SVH

// ****************************************************************
// opcode encodings
// ****************************************************************
`define OP_SLOW_CLK      8'h01
`define OP_CLR_CO        8'h02
`define OP_WDT_CLR       8'h03
`define OP_CMP_ACC_HI    4'h1
`define OP_CMP_IMM_HI    6'h08
`define CMP_IMM_BYTES    2'd3
`define OPERAND_BYTES_1  2'd1

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ADDR_ACC_X       5'h00
`define ADDR_FLAGS       5'h10
`define ADDR_CTRL        5'h14
`define ADDR_STATUS      5'h18
`define ADDR_WDT_COUNT   5'h1c

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define FLAG_Z           0
`define FLAG_S           1
`define FLAG_O           2
`define FLAG_C           3
`define CTRL_RUN         0
`define STAT_SLOW        0
`define STAT_BUSY        1
`define STAT_ILLEGAL     2
`define STAT_WDT_TO      3
`define FLAGS_RST        4'h0
`define ACC_RST          24'h000000
`define CTRL_RUN_RST     1'b0

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS    50
`define SLOW_PERIOD_NS   100000
`define SLOW_DIV_CYCLES  (`SLOW_PERIOD_NS / `CLK_PERIOD_NS)
`define WDT_WIDTH        16
`define WDT_LIMIT        16'hffff

`endif

// [rtl/cpu_pkg.sv]
package cpu_pkg;

  typedef logic [23:0] word_type;
  typedef logic [3:0]  flags_type;

  typedef enum logic [2:0]
  {
    ST_FETCH   = 3'b001,
    ST_OPERAND = 3'b010,
    ST_SETTLE  = 3'b100
  } exec_state_type;

  typedef enum logic [2:0]
  {
    K_CLK = 3'b001,
    K_WDT = 3'b010,
    K_CMP = 3'b100
  } op_kind_type;

endpackage

// [rtl/watchdog_counter.sv]
`timescale 1ns/100ps
`include "cpu_consts.svh"

module watchdog_counter
#(
  parameter int                 WIDTH = `WDT_WIDTH,
  parameter logic [WIDTH-1:0]   LIMIT = `WDT_LIMIT
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // control
  input  wire logic             tick,
  input  wire logic             clear,
  // state
  output logic [WIDTH-1:0]      count,
  output logic                  timeout
);

  logic [WIDTH-1:0] count_next;
  logic             timeout_next;

  always_comb
  begin
    count_next   = count;
    timeout_next = 1'b0;
    // clear beats a tick in the same cycle
    if (clear)
      count_next = '0;
    else if (tick)
    begin
      if (count == LIMIT)
      begin
        count_next   = '0;
        timeout_next = 1'b1;
      end
      else
        count_next = count + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count   <= '0;
      timeout <= 1'b0;
    end
    else
    begin
      count   <= count_next;
      timeout <= timeout_next;
    end
  end

endmodule

// [test/test_cpu_clock_flag_compare_ops.sv]
`timescale 1ns/100ps
`include "cpu_consts.svh"

module test_cpu_clock_flag_compare_ops;
  import cpu_pkg::*;

  // ****************************************************************
  // settings and signals
  // ****************************************************************
  // short slow divider keeps the slow-clock checks within the run budget
  localparam int DIV   = 4;
  localparam int LIMIT = 64;

  typedef struct packed
  {
    logic [7:0] op;
    flags_type  flags;
  } row_type;

  logic        clk;
  logic        rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  instr_byte;
  logic        instr_valid;
  logic        instr_ready;
  logic        slow_clk_sel;
  logic        cpu_tick;
  int          fails;
  int          total_checks;
  int          ticks;
  logic [31:0] rd;
  row_type     rows [5];
  word_type    acc_val [4];

  cpu_clock_flag_compare_ops #(.SLOW_DIV(DIV)) i_dut
  (
    .clk             (clk),
    .rst             (rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .instr_byte      (instr_byte),
    .instr_valid     (instr_valid),
    .instr_ready     (instr_ready),
    .slow_clk_sel    (slow_clk_sel),
    .cpu_tick        (cpu_tick)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic timed_out;
    $display("unexpected at %0t: no answer in time", $time);
    fails++;
    tally_and_finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      fails++;
    end
  endtask

  // one avalon access; a spare edge after release so requests never merge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    n = 0;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
    begin
      n++;
      if (n > LIMIT)
        timed_out;
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  // valid stays up so bytes can follow back to back; idle drops it
  task automatic send(input logic [7:0] b);
    int n;
    instr_byte  <= b;
    instr_valid <= 1'b1;
    n = 0;
    @(negedge clk);
    while (instr_ready !== 1'b1)
    begin
      n++;
      if (n > LIMIT)
        timed_out;
      @(negedge clk);
    end
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    instr_valid <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  task automatic count_ticks(input int n);
    ticks = 0;
    repeat (n)
    begin
      @(negedge clk);
      if (cpu_tick === 1'b1)
        ticks++;
    end
    @(posedge clk);
  endtask

  task automatic flags_are(input flags_type f);
    bus(1'b0, `ADDR_FLAGS, 32'h0);
    chk(rd, {28'h0, f});
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    timed_out;
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    instr_byte = 8'h00;
    instr_valid = 1'b0;
    fails = 0;
    total_checks = 0;
    acc_val = '{24'h000005, 24'h000003, 24'h800000, 24'h7fffff};
    // p2 minus p1 over x=5 y=3 z=800000 r=7fffff; flags C O S Z
    rows[0] = '{8'h10, 4'h1};
    rows[1] = '{8'h11, 4'ha};
    rows[2] = '{8'h14, 4'h0};
    rows[3] = '{8'h1e, 4'h4};
    rows[4] = '{8'h1b, 4'he};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(slow_clk_sel, 1'b0);
    chk(cpu_tick, 1'b1);
    chk(instr_ready, 1'b0);
    @(posedge clk);
    flags_are(4'h0);
    for (int i = 0; i < 4; i++)
      bus(1'b1, 5'(4 * i), {8'h0, acc_val[i]});
    bus(1'b1, `ADDR_CTRL, 32'h1);

    for (int i = 0; i < 5; i++)
    begin
      send(rows[i].op);
      idle(1);
      flags_are(rows[i].flags);
    end

    // immediate compare stalled after three bytes must not touch flags
    send(8'h23);
    send(8'h80);
    send(8'h00);
    idle(1);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd, 32'h2);
    flags_are(4'he);
    send(8'h02);
    idle(1);
    flags_are(4'h4);

    bus(1'b1, `ADDR_FLAGS, 32'hf);
    send(8'h02);
    idle(1);
    flags_are(4'h3);

    bus(1'b1, `ADDR_FLAGS, 32'h5);
    idle(40);
    bus(1'b0, `ADDR_WDT_COUNT, 32'h0);
    chk({31'h0, rd > 32'd8}, 32'h1);
    send(8'h03);
    send(8'haa);
    idle(1);
    bus(1'b0, `ADDR_WDT_COUNT, 32'h0);
    chk({31'h0, rd < 32'd8}, 32'h1);
    flags_are(4'h5);

    send(8'h01);
    send(8'h01);
    idle(0);
    @(negedge clk);
    chk(instr_ready, 1'b0);
    chk(slow_clk_sel, 1'b0);
    @(posedge clk);
    @(negedge clk);
    chk(slow_clk_sel, 1'b1);
    @(posedge clk);
    count_ticks(16);
    chk(32'(ticks), 32'd4);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd, 32'h1);
    send(8'h1e);
    idle(1);
    flags_are(4'h4);

    // back to the normal clock through the same opcode with operand 0
    send(8'h01);
    send(8'h00);
    idle(0);
    for (int n = 0; n < LIMIT && slow_clk_sel !== 1'b0; n++)
      @(negedge clk);
    chk(slow_clk_sel, 1'b0);
    @(posedge clk);
    count_ticks(8);
    chk(32'(ticks), 32'd8);

    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, 5'(4 * i), 32'h0);
      chk(rd, {8'h0, acc_val[i]});
    end
    tally_and_finish;
  end
endmodule
